// file: design/hs_lane_tx.sv
// Host transmitter that sequences one clock lane and one data lane into bursts.
//
// Summary of operation
// - Every low-power line state driven on either lane is held at least 50 ns.
// - The data lane shows LP-00 for 40+4*UI to 85+6*UI ns right before HS-0.
// - Data-lane LP-00 plus HS-0 together last at least 145+10*UI ns before sync.
// - After the last payload bit the inverted bit is driven for the trail time.
// - After a burst the lane stays at LP-11 at least 100 ns before any change.
// - The clock keeps toggling at least 60+52*UI ns after the data lane is back in LP.
// - The clock toggles at least 8*UI before the data lane leaves LP-11.
// - The clock lane shows LP-00 at least 38 ns before HS-0.
// - Clock-lane LP-00 plus HS-0 last at least 300 ns before toggling starts.
// - The clock lane is held at HS-0 for a trail period before it leaves HS mode.
// - One bit period never exceeds 12.5 ns.
`timescale 1ns/1ps
`default_nettype none
module hs_lane_tx
  import hs_lane_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              sys_rst_i,
  input  wire logic [BYTE_W-1:0] tx_data_i,
  input  wire logic              tx_last_i,
  input  wire logic              tx_valid_i,
  output var  logic              tx_ready_o,
  output var  logic              busy_o,
  output var  logic              ck_lp_p_o,
  output var  logic              ck_lp_n_o,
  output var  logic              ck_hs_en_o,
  output var  logic [PAIR_W-1:0] ck_hs_bits_o,
  output var  logic              dl_lp_p_o,
  output var  logic              dl_lp_n_o,
  output var  logic              dl_hs_en_o,
  output var  logic [PAIR_W-1:0] dl_hs_bits_o
);

  typedef struct packed {
    tx_state_t         st;
    logic [CNT_W-1:0]  age;
    logic [BYTE_W-1:0] shreg;
    logic [1:0]        pair_idx;
    logic              last_byte;
    logic              trail_bit;
    logic              busy;
    logic [1:0]        ck_lp;
    logic              ck_hs_en;
    logic [1:0]        ck_hs;
    logic [1:0]        dl_lp;
    logic              dl_hs_en;
    logic [1:0]        dl_hs;
    logic [CNT_W-1:0]  d_lp_age;
    logic [CNT_W-1:0]  c_lp_age;
    logic [CNT_W-1:0]  post_age;
    logic [CNT_W-1:0]  ck_run;
  } tx_t;

  localparam tx_t TX_RESET = '{st: ST_IDLE, age: '0, shreg: '0, pair_idx: '0,
                               last_byte: 1'b0, trail_bit: 1'b0, busy: 1'b0,
                               ck_lp: LP_STOP, ck_hs_en: 1'b0, ck_hs: HS_ZERO_PAIR,
                               dl_lp: LP_STOP, dl_hs_en: 1'b0, dl_hs: HS_ZERO_PAIR,
                               d_lp_age: '0, c_lp_age: '0, post_age: '0, ck_run: '0};

  tx_t               q, d;
  logic [BYTE_W:0]   buf_data;
  logic              buf_valid;
  logic              take;
  logic              ck_toggling;

  // ==========================================================================
  // Input buffer
  // ==========================================================================
  pair_buffer #(
    .WIDTH (BYTE_W + 1),
    .DEPTH (2)
  ) u_buf (
    .clk_i       (clk_i),
    .sys_rst_i   (sys_rst_i),
    .in_data_i   ({tx_last_i, tx_data_i}),
    .in_valid_i  (tx_valid_i),
    .in_ready_o  (tx_ready_o),
    .out_data_o  (buf_data),
    .out_valid_o (buf_valid),
    .out_ready_i (take)
  );

  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
    return (v >= AGE_SAT) ? v : v + CNT_W'(1);
  endfunction : sat_inc

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  always_comb begin
    d    = q;
    take = 1'b0;
    d.age = sat_inc(q.age);
    unique case (q.st)
      ST_IDLE: begin
        if (buf_valid && q.age >= LPX_CYC - CNT_W'(1)) begin
          d.st = ST_CK_REQ;
        end
      end
      ST_CK_REQ: begin
        if (q.age >= LPX_CYC - CNT_W'(1)) begin
          d.st = ST_CK_PREP;
        end
      end
      ST_CK_PREP: begin
        if (q.age >= CLK_PREP_CYC - CNT_W'(1)) begin
          d.st = ST_CK_ZERO;
        end
      end
      ST_CK_ZERO: begin
        if (q.age >= CLK_ZERO_CYC - CNT_W'(1)) begin
          d.st = ST_CK_PRE;
        end
      end
      ST_CK_PRE: begin
        if (q.age >= CLK_PRE_CYC - CNT_W'(1)) begin
          d.st = ST_D_REQ;
        end
      end
      ST_D_REQ: begin
        if (q.age >= LPX_CYC - CNT_W'(1)) begin
          d.st = ST_D_PREP;
        end
      end
      ST_D_PREP: begin
        if (q.age >= HS_PREP_MIN_CYC - CNT_W'(1)) begin
          d.st = ST_D_ZERO;
        end
      end
      ST_D_ZERO: begin
        if (q.age >= HS_ZERO_CYC - CNT_W'(1)) begin
          d.st       = ST_D_SYNC;
          d.shreg    = SYNC_BYTE;
          d.pair_idx = '0;
        end
      end
      ST_D_SYNC, ST_D_DATA: begin
        d.shreg    = q.shreg >> PAIR_W;
        d.pair_idx = q.pair_idx + 2'h1;
        if (q.pair_idx == 2'(BYTE_PAIRS - 1)) begin
          // A byte boundary: fetch the next word, or close the burst when the
          // stream ended or ran dry, since a running burst cannot pause.
          if (buf_valid && !(q.st == ST_D_DATA && q.last_byte)) begin
            take        = 1'b1;
            d.st        = ST_D_DATA;
            d.shreg     = buf_data[BYTE_W-1:0];
            d.last_byte = buf_data[BYTE_W];
            d.pair_idx  = '0;
          end else begin
            d.st        = ST_D_TRAIL;
            d.trail_bit = ~q.dl_hs[1];
          end
        end
      end
      ST_D_TRAIL: begin
        if (q.age >= TRAIL_CYC - CNT_W'(1)) begin
          d.st = ST_CK_POST;
        end
      end
      ST_CK_POST: begin
        if (q.age >= POST_EXIT_CYC - CNT_W'(1)) begin
          d.st = ST_CK_TRAIL;
        end
      end
      ST_CK_TRAIL: begin
        if (q.age >= CLK_TRAIL_CYC - CNT_W'(1)) begin
          d.st = ST_EXIT;
        end
      end
      ST_EXIT: begin
        if (q.age >= EXIT_CYC - CNT_W'(1)) begin
          d.st = ST_IDLE;
        end
      end
    endcase
    if (d.st != q.st) begin
      d.age = '0;
    end

    // Pin levels follow the state that the lanes enter next.
    d.busy = (d.st != ST_IDLE);
    unique case (d.st)
      ST_IDLE, ST_EXIT:                   d.ck_lp = LP_STOP;
      ST_CK_REQ:                          d.ck_lp = LP_REQUEST;
      default:                            d.ck_lp = LP_BRIDGE;
    endcase
    d.ck_hs_en = !(d.st inside {ST_IDLE, ST_EXIT, ST_CK_REQ, ST_CK_PREP});
    d.ck_hs    = (d.st inside {ST_CK_ZERO, ST_CK_TRAIL}) ? HS_ZERO_PAIR
               : (d.ck_hs_en ? CLK_TOGGLE_PAIR : HS_ZERO_PAIR);
    unique case (d.st)
      ST_D_REQ:                           d.dl_lp = LP_REQUEST;
      ST_D_PREP, ST_D_ZERO, ST_D_SYNC,
      ST_D_DATA, ST_D_TRAIL:              d.dl_lp = LP_BRIDGE;
      default:                            d.dl_lp = LP_STOP;
    endcase
    d.dl_hs_en = (d.st inside {ST_D_ZERO, ST_D_SYNC, ST_D_DATA, ST_D_TRAIL});
    unique case (d.st)
      ST_D_SYNC, ST_D_DATA:               d.dl_hs = d.shreg[PAIR_W-1:0];
      ST_D_TRAIL:                         d.dl_hs = {PAIR_W{d.trail_bit}};
      default:                            d.dl_hs = HS_ZERO_PAIR;
    endcase

    // Ages of the visible line states, read by the checks below.
    d.d_lp_age = (d.dl_lp != q.dl_lp) ? '0 : sat_inc(q.d_lp_age);
    d.c_lp_age = (d.ck_lp != q.ck_lp) ? '0 : sat_inc(q.c_lp_age);
    d.post_age = (q.dl_hs_en && !d.dl_hs_en) ? '0 : sat_inc(q.post_age);
    d.ck_run   = ck_toggling ? sat_inc(q.ck_run) : '0;
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      q <= TX_RESET;
    end else begin
      q <= d;
    end
  end

  assign ck_toggling  = q.ck_hs_en && (q.ck_hs == CLK_TOGGLE_PAIR);
  assign busy_o       = q.busy;
  assign ck_lp_p_o    = q.ck_lp[1];
  assign ck_lp_n_o    = q.ck_lp[0];
  assign ck_hs_en_o   = q.ck_hs_en;
  assign ck_hs_bits_o = q.ck_hs;
  assign dl_lp_p_o    = q.dl_lp[1];
  assign dl_lp_n_o    = q.dl_lp[0];
  assign dl_hs_en_o   = q.dl_hs_en;
  assign dl_hs_bits_o = q.dl_hs;

  // ==========================================================================
  // Checks
  // ==========================================================================
  property p_data_lpx;
    @(posedge clk_i) disable iff (sys_rst_i)
    ($changed(q.dl_lp) && !$past(q.dl_hs_en)) |-> $past(q.d_lp_age) >= LPX_CYC - CNT_W'(1);
  endproperty
  a_data_lpx: assert property (p_data_lpx) else $error("data LP state too short");

  property p_clock_lpx;
    @(posedge clk_i) disable iff (sys_rst_i)
    ($changed(q.ck_lp) && !$past(q.ck_hs_en)) |-> $past(q.c_lp_age) >= LPX_CYC - CNT_W'(1);
  endproperty
  a_clock_lpx: assert property (p_clock_lpx) else $error("clock LP state too short");

  property p_data_prepare;
    @(posedge clk_i) disable iff (sys_rst_i)
    $rose(dl_hs_en_o) |-> (dl_lp_p_o == 1'b0) && (dl_lp_n_o == 1'b0) &&
      (q.d_lp_age >= HS_PREP_MIN_CYC) && (q.d_lp_age <= HS_PREP_MAX_CYC);
  endproperty
  a_data_prepare: assert property (p_data_prepare) else $error("data prepare out of range");

  property p_data_zero;
    @(posedge clk_i) disable iff (sys_rst_i)
    (q.st == ST_D_SYNC && $past(q.st) == ST_D_ZERO) |-> q.d_lp_age >= HS_PREP_ZERO_CYC;
  endproperty
  a_data_zero: assert property (p_data_zero) else $error("data prepare plus zero too short");

  property p_data_trail;
    @(posedge clk_i) disable iff (sys_rst_i)
    ($past(q.st) == ST_D_TRAIL && q.st != ST_D_TRAIL) |->
      $past(q.age) >= TRAIL_CYC - CNT_W'(1) && $past(dl_hs_bits_o) == {PAIR_W{q.trail_bit}};
  endproperty
  a_data_trail: assert property (p_data_trail) else $error("data trail too short");

  property p_data_exit;
    @(posedge clk_i) disable iff (sys_rst_i)
    $fell(dl_hs_en_o) |-> (dl_lp_p_o && dl_lp_n_o)[*4];
  endproperty
  a_data_exit: assert property (p_data_exit) else $error("data stop state too short");

  property p_clock_post;
    @(posedge clk_i) disable iff (sys_rst_i)
    $fell(ck_toggling) |-> q.post_age >= CLK_POST_CYC && !dl_hs_en_o;
  endproperty
  a_clock_post: assert property (p_clock_post) else $error("clock stopped too early");

  property p_clock_pre;
    @(posedge clk_i) disable iff (sys_rst_i)
    ($past(q.dl_lp) == LP_STOP && q.dl_lp != LP_STOP) |-> ck_toggling && q.ck_run >= CLK_PRE_CYC;
  endproperty
  a_clock_pre: assert property (p_clock_pre) else $error("clock not running before data");

  property p_clock_prepare;
    @(posedge clk_i) disable iff (sys_rst_i)
    $rose(ck_hs_en_o) |-> !ck_lp_p_o && !ck_lp_n_o && q.c_lp_age >= CLK_PREP_CYC;
  endproperty
  a_clock_prepare: assert property (p_clock_prepare) else $error("clock prepare too short");

  property p_clock_zero;
    @(posedge clk_i) disable iff (sys_rst_i)
    $rose(ck_toggling) |-> q.c_lp_age >= CLK_PREP_ZERO_CYC;
  endproperty
  a_clock_zero: assert property (p_clock_zero) else $error("clock prepare plus zero short");

  property p_clock_trail;
    @(posedge clk_i) disable iff (sys_rst_i)
    $fell(ck_hs_en_o) |-> $past(ck_hs_bits_o) == HS_ZERO_PAIR && ck_lp_p_o && ck_lp_n_o;
  endproperty
  a_clock_trail: assert property (p_clock_trail) else $error("clock left HS without trail");

  // A fresh pair must leave on every cycle of a running burst, so that one bit
  // lasts half a clock period and stays inside the longest allowed bit period.
  property p_bit_period;
    @(posedge clk_i) disable iff (sys_rst_i)
    (q.st inside {ST_D_SYNC, ST_D_DATA}) |=>
      (q.pair_idx != $past(q.pair_idx)) && (UI_PS <= UI_MAX_PS);
  endproperty
  a_bit_period: assert property (p_bit_period) else $error("bit period too long");

endmodule : hs_lane_tx
`default_nettype wire

// file: pkg/hs_lane_pkg.sv
// Constants, timing counts and state codes of the high-speed lane transmitter.
package hs_lane_pkg;

  // ==========================================================================
  // Clock and bit period
  // ==========================================================================
  localparam int CLK_PERIOD_PS = 25000;
  // Two bits leave per clock cycle, so one bit lasts half a clock period.
  localparam int UI_PS         = CLK_PERIOD_PS / 2;
  localparam int UI_MAX_PS     = 12500;
  localparam int CNT_W         = 8;
  localparam int PAIR_W        = 2;
  localparam int BYTE_W        = 8;
  localparam int BYTE_PAIRS    = BYTE_W / PAIR_W;
  localparam int TRAIL_N       = 1;

  // ==========================================================================
  // Printed times in ns and unit-interval multiples, and the clock trail minimum in cycles
  // ==========================================================================
  localparam int LPX_NS            = 50;
  localparam int HS_PREP_MIN_NS    = 40;
  localparam int HS_PREP_MIN_UI    = 4;
  localparam int HS_PREP_MAX_NS    = 85;
  localparam int HS_PREP_MAX_UI    = 6;
  localparam int HS_PREP_ZERO_NS   = 145;
  localparam int HS_PREP_ZERO_UI   = 10;
  localparam int TRAIL_BASE_NS     = 60;
  localparam int TRAIL_LONG_UI     = 8;
  localparam int TRAIL_SHORT_UI    = 4;
  localparam int EXIT_NS           = 100;
  localparam int CLK_POST_NS       = 60;
  localparam int CLK_POST_UI       = 52;
  localparam int CLK_PRE_UI        = 8;
  localparam int CLK_PREP_NS       = 38;
  localparam int CLK_PREP_ZERO_NS  = 300;
  localparam int CLK_TRAIL_MIN_CYC = 1;

  function automatic int ceil_cyc(input int ps);
    int c;
    c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction : ceil_cyc

  function automatic int floor_cyc(input int ps);
    int c;
    c = ps / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction : floor_cyc

  function automatic int max2(input int a, input int b);
    return (a > b) ? a : b;
  endfunction : max2

  // ==========================================================================
  // Cycle counts
  // ==========================================================================
  localparam logic [CNT_W-1:0] LPX_CYC          = CNT_W'(ceil_cyc(LPX_NS * 1000));
  localparam logic [CNT_W-1:0] HS_PREP_MIN_CYC  =
    CNT_W'(ceil_cyc(HS_PREP_MIN_NS * 1000 + HS_PREP_MIN_UI * UI_PS));
  localparam logic [CNT_W-1:0] HS_PREP_MAX_CYC  =
    CNT_W'(floor_cyc(HS_PREP_MAX_NS * 1000 + HS_PREP_MAX_UI * UI_PS));
  localparam logic [CNT_W-1:0] HS_PREP_ZERO_CYC =
    CNT_W'(ceil_cyc(HS_PREP_ZERO_NS * 1000 + HS_PREP_ZERO_UI * UI_PS));
  localparam logic [CNT_W-1:0] HS_ZERO_CYC      = HS_PREP_ZERO_CYC - HS_PREP_MIN_CYC;
  localparam logic [CNT_W-1:0] TRAIL_CYC        = CNT_W'(ceil_cyc(max2(
    TRAIL_N * TRAIL_LONG_UI * UI_PS, TRAIL_BASE_NS * 1000 + TRAIL_N * TRAIL_SHORT_UI * UI_PS)));
  localparam logic [CNT_W-1:0] EXIT_CYC         = CNT_W'(ceil_cyc(EXIT_NS * 1000));
  localparam logic [CNT_W-1:0] CLK_POST_CYC     =
    CNT_W'(ceil_cyc(CLK_POST_NS * 1000 + CLK_POST_UI * UI_PS));
  localparam logic [CNT_W-1:0] CLK_PRE_CYC      = CNT_W'(ceil_cyc(CLK_PRE_UI * UI_PS));
  localparam logic [CNT_W-1:0] CLK_PREP_CYC     = CNT_W'(ceil_cyc(CLK_PREP_NS * 1000));
  localparam logic [CNT_W-1:0] CLK_PREP_ZERO_CYC = CNT_W'(ceil_cyc(CLK_PREP_ZERO_NS * 1000));
  localparam logic [CNT_W-1:0] CLK_ZERO_CYC     = CLK_PREP_ZERO_CYC - CLK_PREP_CYC;
  localparam logic [CNT_W-1:0] CLK_TRAIL_CYC    = CNT_W'(CLK_TRAIL_MIN_CYC);
  localparam logic [CNT_W-1:0] POST_EXIT_CYC    =
    (CLK_POST_CYC > EXIT_CYC) ? CLK_POST_CYC : EXIT_CYC;
  localparam logic [CNT_W-1:0] AGE_SAT          = 8'hfe;

  // ==========================================================================
  // Line codes: low-power pairs are {p, n}; high-speed pairs send bit 0 first
  // ==========================================================================
  localparam logic [1:0] LP_STOP         = 2'h3;
  localparam logic [1:0] LP_REQUEST      = 2'h1;
  localparam logic [1:0] LP_BRIDGE       = 2'h0;
  localparam logic [1:0] HS_ZERO_PAIR    = 2'h0;
  localparam logic [1:0] CLK_TOGGLE_PAIR = 2'h2;
  localparam logic [7:0] SYNC_BYTE       = 8'hb8;

  typedef enum logic [13:0] {
    ST_IDLE     = 14'h0001,
    ST_CK_REQ   = 14'h0002,
    ST_CK_PREP  = 14'h0004,
    ST_CK_ZERO  = 14'h0008,
    ST_CK_PRE   = 14'h0010,
    ST_D_REQ    = 14'h0020,
    ST_D_PREP   = 14'h0040,
    ST_D_ZERO   = 14'h0080,
    ST_D_SYNC   = 14'h0100,
    ST_D_DATA   = 14'h0200,
    ST_D_TRAIL  = 14'h0400,
    ST_CK_POST  = 14'h0800,
    ST_CK_TRAIL = 14'h1000,
    ST_EXIT     = 14'h2000
  } tx_state_t;

endpackage : hs_lane_pkg

// file: design/pair_buffer.sv
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module pair_buffer #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 2
) (
  input  wire logic             clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output var  logic             in_ready_o,
  output var  logic [WIDTH-1:0] out_data_o,
  output var  logic             out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0]            wr_ptr;
    logic [PTR_W-1:0]            rd_ptr;
    logic [CNT_W-1:0]            count;
    logic                        in_ready;
  } buf_t;

  buf_t q, d;
  logic push, pop;

  always_comb begin
    d    = q;
    push = in_valid_i && q.in_ready;
    pop  = out_valid_o && out_ready_i;
    if (push) begin
      d.mem[q.wr_ptr] = in_data_i;
      d.wr_ptr = (q.wr_ptr == PTR_LAST) ? '0 : q.wr_ptr + PTR_W'(1);
    end
    if (pop) begin
      d.rd_ptr = (q.rd_ptr == PTR_LAST) ? '0 : q.rd_ptr + PTR_W'(1);
    end
    if (push && !pop) begin
      d.count = q.count + CNT_W'(1);
    end else if (pop && !push) begin
      d.count = q.count - CNT_W'(1);
    end
    // Ready is registered, so the writer sees back-pressure one cycle late
    // only in the safe direction: it drops as soon as the last slot fills.
    d.in_ready = (d.count != CNT_FULL);
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      q <= '{mem: '0, wr_ptr: '0, rd_ptr: '0, count: '0, in_ready: 1'b1};
    end else begin
      q <= d;
    end
  end

  assign in_ready_o  = q.in_ready;
  assign out_valid_o = (q.count != '0);
  assign out_data_o  = q.mem[q.rd_ptr];

endmodule : pair_buffer
`default_nettype wire

// file: verif/panel_rx_model.sv
// Behavioural panel receiver that recovers bytes from the data lane.
`timescale 1ns/1ps
`default_nettype none
module panel_rx_model
  import hs_lane_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              sys_rst_i,
  input  wire logic              ck_lp_p_i,
  input  wire logic              ck_lp_n_i,
  input  wire logic              ck_hs_en_i,
  input  wire logic              dl_lp_p_i,
  input  wire logic              dl_lp_n_i,
  input  wire logic              dl_hs_en_i,
  input  wire logic [PAIR_W-1:0] dl_hs_bits_i,
  output var  logic [BYTE_W-1:0] rx_byte_o,
  output var  logic              rx_valid_o,
  output var  logic              ck_term_o,
  output var  logic              dl_term_o
);
  localparam int SETTLE_CYC =
    (HS_PREP_MAX_NS * 1000 + HS_PREP_MAX_UI * UI_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  logic [7:0] sr_q;
  logic [7:0] pend_q;
  logic [7:0] nsr;
  logic [3:0] age_q;
  logic [1:0] cnt_q;
  logic       lock_q;
  logic       pv_q;
  assign nsr = {dl_hs_bits_i, sr_q[7:2]};
  // One byte is held back so that the completed trail byte is never delivered.
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      {sr_q, pend_q, age_q, cnt_q, lock_q, pv_q} <= '0;
      {rx_byte_o, rx_valid_o, ck_term_o, dl_term_o} <= '0;
    end else begin
      rx_valid_o <= 1'b0;
      ck_term_o  <= ck_hs_en_i | (!ck_lp_p_i && !ck_lp_n_i);
      if (!dl_hs_en_i && dl_lp_p_i && dl_lp_n_i) begin
        {sr_q, age_q, cnt_q, lock_q, pv_q, dl_term_o} <= '0;
      end else if (dl_hs_en_i || (!dl_lp_p_i && !dl_lp_n_i)) begin
        dl_term_o <= 1'b1;
        if (age_q != 4'hf) age_q <= age_q + 4'h1;
        if (dl_hs_en_i && age_q >= SETTLE_CYC) begin
          sr_q <= nsr;
          if (!lock_q && nsr == SYNC_BYTE) begin
            lock_q <= 1'b1;
            cnt_q  <= 2'h0;
          end else if (lock_q) begin
            cnt_q <= cnt_q + 2'h1;
            if (cnt_q == 2'h3) begin
              rx_byte_o  <= pend_q;
              rx_valid_o <= pv_q;
              pend_q     <= nsr;
              pv_q       <= 1'b1;
            end
          end
        end
      end
    end
  end
endmodule : panel_rx_model
`default_nettype wire

// file: verif/hs_lane_tx_tb.sv
// Self-checking testbench of the lane transmitter with a panel receiver model.
`timescale 1ns/1ps
`default_nettype none
module hs_lane_tx_tb;
  import hs_lane_pkg::*;
  logic       clk_i, sys_rst_i, tx_last_i, tx_valid_i, tx_ready_o, busy_o;
  logic [7:0] tx_data_i, rx_byte;
  logic       ck_lp_p_o, ck_lp_n_o, ck_hs_en_o, dl_lp_p_o, dl_lp_n_o, dl_hs_en_o, rx_valid;
  logic [1:0] ck_hs_bits_o, dl_hs_bits_o;
  logic [2:0] dc, cc, dp, cp, dpp;
  logic       dx;
  int         dr, cr, dprep, cprep, stalled, i;
  int         bad_count, samples_checked;
  int         seed = 70076;
  logic [7:0] exp_q[$];

  hs_lane_tx hs_lane_tx_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .tx_data_i(tx_data_i),
    .tx_last_i(tx_last_i), .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o), .busy_o(busy_o),
    .ck_lp_p_o(ck_lp_p_o), .ck_lp_n_o(ck_lp_n_o), .ck_hs_en_o(ck_hs_en_o),
    .ck_hs_bits_o(ck_hs_bits_o), .dl_lp_p_o(dl_lp_p_o), .dl_lp_n_o(dl_lp_n_o),
    .dl_hs_en_o(dl_hs_en_o), .dl_hs_bits_o(dl_hs_bits_o));
  panel_rx_model panel_rx_model_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .ck_lp_p_i(ck_lp_p_o), .ck_lp_n_i(ck_lp_n_o), .ck_hs_en_i(ck_hs_en_o),
    .dl_lp_p_i(dl_lp_p_o), .dl_lp_n_i(dl_lp_n_o), .dl_hs_en_i(dl_hs_en_o),
    .dl_hs_bits_i(dl_hs_bits_o), .rx_byte_o(rx_byte), .rx_valid_o(rx_valid),
    .ck_term_o(), .dl_term_o());

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // ==========================================================================
  // Checking and closing
  // ==========================================================================
  task automatic check(input logic [31:0] seen, input logic [31:0] expd);
    samples_checked++;
    if (seen !== expd) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, expd);
    end
  endtask : check

  task automatic finish_test();
    $display("checks %0d errors %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  initial begin
    #(20000 * 25);
    bad_count++;
    finish_test();
  end

  // ==========================================================================
  // Lane monitor: run lengths of each line state
  // ==========================================================================
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      {dp, cp} = 6'b011_011;
      {dr, cr, dprep, cprep, stalled} = '0;
      dx = 1'b0;
    end else begin
      if (tx_valid_i && !tx_ready_o) stalled++;
      dc = {dl_hs_en_o, dl_hs_en_o ? dl_hs_bits_o : {dl_lp_p_o, dl_lp_n_o}};
      cc = {ck_hs_en_o, ck_hs_en_o ? ck_hs_bits_o : {ck_lp_p_o, ck_lp_n_o}};
      if (cc !== cp) begin
        if (!cp[2]) check(cr >= LPX_CYC, 1);
        if (cp == 3'b000) begin
          check(cr >= CLK_PREP_CYC, 1);
          cprep = cr;
        end
        if (cp == 3'b100 && cc == 3'b110) check(cprep + cr >= CLK_PREP_ZERO_CYC, 1);
        if (cp == 3'b100 && !cc[2]) check(cr >= CLK_TRAIL_CYC, 1);
        if (cp == 3'b110) check({dc, dr >= CLK_POST_CYC}, {3'b011, 1'b1});
        cp = cc;
        cr = 1;
      end else cr = cr + 1;
      if (dc !== dp) begin
        if (!dp[2]) check(dr >= (dx ? EXIT_CYC : LPX_CYC), 1);
        if (dp == 3'b000 && dc[2]) begin
          check(dr >= HS_PREP_MIN_CYC && dr <= HS_PREP_MAX_CYC, 1);
          dprep = dr;
        end
        if (dp == 3'b100 && dprep != 0) begin
          check(dprep + dr >= HS_PREP_ZERO_CYC, 1);
          dprep = 0;
        end
        if (dp[2] && !dc[2]) check({dr >= TRAIL_CYC, dp[1:0]}, {1'b1, ~dpp[1], ~dpp[1]});
        if (dp == 3'b011 && dc == 3'b001) check({cc, cr >= CLK_PRE_CYC}, {3'b110, 1'b1});
        dx = dp[2] && !dc[2];
        dpp = dp;
        dp = dc;
        dr = 1;
      end else dr = dr + 1;
    end
  end

  always @(posedge clk_i) begin
    if (rx_valid) begin
      if (exp_q.size() == 0) check(1, 0);
      else check(rx_byte, exp_q.pop_front());
    end
  end

  // ==========================================================================
  // Stimulus
  // ==========================================================================
  task automatic send(input logic [7:0] d, input logic l);
    int n;
    @(negedge clk_i);
    tx_data_i = d;
    tx_last_i = l;
    tx_valid_i = 1'b1;
    n = 0;
    @(posedge clk_i);
    while (tx_ready_o !== 1'b1 && n < 500) begin
      n++;
      @(posedge clk_i);
    end
    exp_q.push_back(d);
  endtask : send

  task automatic idle(input int g);
    @(negedge clk_i);
    tx_valid_i = 1'b0;
    repeat (g) @(negedge clk_i);
  endtask : idle

  initial begin
    sys_rst_i = 1'b1;
    tx_data_i = 8'h00;
    tx_last_i = 1'b0;
    tx_valid_i = 1'b0;
    repeat (6) @(posedge clk_i);
    @(negedge clk_i);
    check({tx_ready_o, busy_o, ck_lp_p_o, ck_lp_n_o, ck_hs_en_o, ck_hs_bits_o, dl_lp_p_o,
           dl_lp_n_o, dl_hs_en_o, dl_hs_bits_o}, 12'hb18);
    check(UI_PS <= UI_MAX_PS, 1);
    sys_rst_i = 1'b0;
    send(8'h5a, 1'b1);
    idle(150);
    for (i = 0; i < 12; i++) begin
      send((i == 0) ? 8'h00 : (i == 1) ? 8'hff : (i == 2) ? SYNC_BYTE : 8'($random(seed)),
           i == 11);
    end
    for (i = 0; i < 40; i++) begin
      send(8'($random(seed)), ($random(seed) & 3) == 0);
      if (($random(seed) & 3) == 0) idle($random(seed) & 63);
    end
    idle(1);
    i = 0;
    while ((exp_q.size() != 0 || busy_o !== 1'b0) && i < 3000) begin
      i++;
      @(posedge clk_i);
    end
    check(exp_q.size(), 0);
    check({busy_o, dl_lp_p_o, dl_lp_n_o, ck_lp_p_o, ck_lp_n_o}, 5'b01111);
    check(stalled > 0, 1);
    finish_test();
  end
endmodule : hs_lane_tx_tb
`default_nettype wire
